// ### host_bus_model.sv
module host_bus_model (
  // clock
  input wire logic mclk,
  // device side of the data pins
  input wire logic [7:0] dev_oe,
  input wire logic [7:0] dev_out,
  // resolved pins
  output logic [7:0] bus,
  output logic [2:0] idx,
  output logic rd,
  output logic stb_n,
  output logic ack_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hval = 8'h5A;
  initial {idx, rd, stb_n, ack_n} = 6'h07;
  // released lines show the inverse of the last value
  assign bus = (dev_oe & dev_out) | (~dev_oe & hval);
  task automatic access(input logic dma, input logic r, input logic [2:0] i,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    #1;
    idx = i;
    rd = r;
    hval = r ? ~hval : d;
    ack_n = !dma;
    stb_n = 1'b0;
    repeat (5) @(posedge mclk);
    q = bus;
    #1;
    stb_n = 1'b1;
    ack_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    hval = ~hval;
    idx = ~idx;
  endtask
endmodule // host_bus_model

// ### host_port_asserts.sv
module host_port_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic host_port_select,
  input wire host_port_pkg::gpio_ctrl_t gpio_ctrl,
  input wire logic [7:0] host_data_lines_oe,
  input wire logic [7:0] host_data_lines_out,
  input wire logic host_access_strobe_n_in,
  input wire logic host_direction_line_in,
  input wire logic host_dma_acknowledge_n,
  input wire logic host_service_request_n_out,
  input wire logic host_service_request_n_oe,
  input wire logic service_pending,
  input wire logic [7:0] dma_out_data,
  input wire logic [2:0] host_register_index_out,
  input wire logic [2:0] host_register_index_oe,
  input wire logic host_direction_line_out,
  input wire logic host_direction_line_oe,
  input wire logic host_access_strobe_n_out,
  input wire logic host_access_strobe_n_oe,
  input wire logic rx_valid
);
  wire logic sel = host_port_select;
  wire logic stb = host_access_strobe_n_in;
  wire logic ack = host_dma_acknowledge_n;
  wire logic rd = host_direction_line_in;
  wire logic [7:0] doe = host_data_lines_oe;
  wire logic req = host_service_request_n_oe;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  idle_tristate_a:
    assert property ((sel && stb && ack)[*5] |-> doe == 8'h00) else $error("idle bus driven");
  read_drive_a:
    assert property (sel && $fell(stb) && rd && ack |-> ##3 doe == 8'hFF) else $error("read undriven");
  write_hiz_a:
    assert property (sel && $fell(stb) && !rd && ack |=> (doe == 8'h00)[*5])
    else $error("write bus driven");
  write_push_a:
    assert property (sel && $rose(stb) && !rd && ack |-> ##[3:8] rx_valid) else $error("no word");
  dma_drive_a:
    assert property (sel && req && $fell(stb) && !ack |-> ##3 doe == 8'hFF
      && host_data_lines_out == dma_out_data) else $error("dma undriven");
  gpio_follow_a:
    assert property (!sel |=> {doe, host_data_lines_out}
      == $past({gpio_ctrl.dir[7:0], gpio_ctrl.dout[7:0]})) else $error("gpio mismatch");
  reset_idle_a:
    assert property ($past(rst) |-> doe == 8'h00 && !req) else $error("not idle after reset");
  req_low_a:
    assert property (host_service_request_n_out == 1'b0) else $error("request drives high");
  req_follow_a:
    assert property (!$past(rst) |-> req == $past(sel && service_pending))
    else $error("request wrong");
  gpio_ctl_follow_a:
    assert property (!sel |=> {host_access_strobe_n_oe, host_direction_line_oe,
      host_register_index_oe, host_access_strobe_n_out, host_direction_line_out,
      host_register_index_out} == $past({gpio_ctrl.dir[12:8], gpio_ctrl.dout[12:8]}))
    else $error("gpio control mismatch");
  host_pins_in_a:
    assert property (sel |=> {host_access_strobe_n_oe, host_direction_line_oe,
      host_register_index_oe} == 5'h00) else $error("host inputs driven");
  cover property (sel && $fell(stb) && rd);
  cover property (req && !ack);
  cover property (rx_valid);
endmodule // host_port_asserts

bind host_port_pin_control host_port_asserts u_chk (.*);

// ### host_port_defines.svh
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH

`define HP_DATA_W 8
`define HP_INDEX_W 3
`define HP_REG_COUNT 8
`define HP_GPIO_W 13
`define HP_GPIO_DATA_LSB 0
`define HP_GPIO_INDEX_LSB 8
`define HP_GPIO_DIR_BIT 11
`define HP_GPIO_STROBE_BIT 12
`define HP_FIFO_DEPTH 16
`define HP_FIFO_AW 4
`define HP_REG_RESET 8'h00
`define HP_GPIO_RESET 13'h0000

`endif

// ### host_port_pin_control.sv
// How it works
// - selected and strobe idle: data lines tri-stated
// - strobe active, direction high: drive register
// - strobe active, direction low: lines stay inputs
// - write data captured at strobe rising edge
// - acknowledge during request drives bus out
// - three-bit index chooses the register
// - unselected port pins are gpio bits 0-12
// - after reset all shared pins gpio inputs
// - service request is open-drain, pulls low
`include "host_port_defines.svh"

module host_port_pin_control (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // mode selection from core
  input wire logic host_port_select,
  // gpio control from core when port unselected
  input wire host_port_pkg::gpio_ctrl_t gpio_ctrl,
  output logic [`HP_GPIO_W-1:0] gpio_pin_state,
  // host data lines, split
  input wire logic [`HP_DATA_W-1:0] host_data_lines_in,
  output logic [`HP_DATA_W-1:0] host_data_lines_out,
  output logic [`HP_DATA_W-1:0] host_data_lines_oe,
  // index, direction, strobe (pins shared with gpio)
  input wire logic [`HP_INDEX_W-1:0] host_register_index_in,
  output logic [`HP_INDEX_W-1:0] host_register_index_out,
  output logic [`HP_INDEX_W-1:0] host_register_index_oe,
  input wire logic host_direction_line_in,
  output logic host_direction_line_out,
  output logic host_direction_line_oe,
  input wire logic host_access_strobe_n_in,
  output logic host_access_strobe_n_out,
  output logic host_access_strobe_n_oe,
  // dma handshake
  input wire logic host_dma_acknowledge_n,
  output logic host_service_request_n_out,
  output logic host_service_request_n_oe,
  // core side: register image the host reads
  input wire logic [`HP_INDEX_W-1:0] core_wr_index,
  input wire logic [`HP_DATA_W-1:0] core_wr_data,
  input wire logic core_wr_en,
  input wire logic service_pending,
  input wire logic [`HP_DATA_W-1:0] dma_out_data,
  // core side: words written by host, through fifo
  output logic rx_valid,
  input wire logic rx_ready,
  output host_port_pkg::host_word_t rx_word
);
  import host_port_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [`HP_GPIO_W-1:0] pin_s1;
    logic [`HP_GPIO_W-1:0] pin_s2;
    logic ack_s1;
    logic ack_s2;
    access_state_t acc;
    logic [`HP_DATA_W*`HP_REG_COUNT-1:0] regs;
    logic [`HP_INDEX_W-1:0] wr_idx;
    logic push;
    host_word_t push_word;
    logic overflow;
    bus_drive_t bus;
    logic [`HP_INDEX_W-1:0] idx_oe;
    logic [`HP_INDEX_W-1:0] idx_out;
    logic dir_oe;
    logic dir_out;
    logic stb_oe;
    logic stb_out;
    logic req_oe;
    logic [`HP_GPIO_W-1:0] gpio_state;
    logic rx_valid;
    host_word_t rx_word;
  } port_state_t;

  port_state_t st_r;
  port_state_t st_nxt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [$bits(host_word_t)-1:0] fifo_out_data;
  logic drain;

  // ----------------------------------------
  // register image access
  // ----------------------------------------
  // read one register of the image
  function automatic logic [`HP_DATA_W-1:0] reg_pick(
    input logic [`HP_DATA_W*`HP_REG_COUNT-1:0] regs,
    input logic [`HP_INDEX_W-1:0] idx
  );
    reg_pick = regs[idx*`HP_DATA_W +: `HP_DATA_W];
  endfunction

  // replace one register of the image
  function automatic logic [`HP_DATA_W*`HP_REG_COUNT-1:0] reg_put(
    input logic [`HP_DATA_W*`HP_REG_COUNT-1:0] regs,
    input logic [`HP_INDEX_W-1:0] idx,
    input logic [`HP_DATA_W-1:0] val
  );
    reg_put = regs;
    reg_put[idx*`HP_DATA_W +: `HP_DATA_W] = val;
  endfunction

  // ----------------------------------------
  // host write fifo
  // ----------------------------------------
  assign drain = !st_r.rx_valid || rx_ready;

  host_word_fifo #(
    .WIDTH($bits(host_word_t)),
    .DEPTH(`HP_FIFO_DEPTH),
    .AW(`HP_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(st_r.push),
    .in_ready(fifo_in_ready),
    .in_data(st_r.push_word),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic [`HP_DATA_W-1:0] data_s;
    logic [`HP_INDEX_W-1:0] idx_s;
    logic dir_s;
    logic strobe_on;
    logic ack_on;
    data_s = st_r.pin_s2[`HP_GPIO_INDEX_LSB-1:`HP_GPIO_DATA_LSB];
    idx_s = st_r.pin_s2[`HP_GPIO_DIR_BIT-1:`HP_GPIO_INDEX_LSB];
    dir_s = st_r.pin_s2[`HP_GPIO_DIR_BIT];
    strobe_on = !st_r.pin_s2[`HP_GPIO_STROBE_BIT];
    ack_on = !st_r.ack_s2;
    st_nxt = st_r;
    // pins are asynchronous to mclk: two flops before use
    st_nxt.pin_s1 = {host_access_strobe_n_in, host_direction_line_in,
                     host_register_index_in, host_data_lines_in};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.ack_s1 = host_dma_acknowledge_n;
    st_nxt.ack_s2 = st_r.ack_s1;
    st_nxt.push = 1'b0;
    st_nxt.gpio_state = st_r.pin_s2;
    // pulls low only; the pull-up holds it high otherwise
    st_nxt.req_oe = host_port_select && service_pending;
    if (core_wr_en)
    begin
      st_nxt.regs = reg_put(st_r.regs, core_wr_index, core_wr_data);
    end
    // a word offered to a full fifo is lost; remembered here
    if (st_r.push && !fifo_in_ready)
    begin
      st_nxt.overflow = 1'b1;
    end
    if (host_port_select)
    begin
      st_nxt.idx_oe = '0;
      st_nxt.dir_oe = 1'b0;
      st_nxt.stb_oe = 1'b0;
      case (st_r.acc)
        ST_IDLE:
        begin
          if (ack_on && st_r.req_oe)
          begin
            st_nxt.acc = ST_DMA;
          end
          else if (strobe_on && dir_s)
          begin
            st_nxt.acc = ST_READ;
          end
          else if (strobe_on)
          begin
            st_nxt.acc = ST_WRITE;
            st_nxt.wr_idx = idx_s;
          end
        end
        ST_READ:
        begin
          if (!strobe_on)
          begin
            st_nxt.acc = ST_IDLE;
          end
        end
        ST_WRITE:
        begin
          if (!strobe_on)
          begin
            // strobe rising edge latches data
            st_nxt.acc = ST_IDLE;
            // host write overrides a same-cycle core write
            st_nxt.regs = reg_put(st_nxt.regs, st_r.wr_idx, data_s);
            st_nxt.push_word.data = data_s;
            st_nxt.push_word.index = st_r.wr_idx;
            st_nxt.push = 1'b1;
          end
        end
        ST_DMA:
        begin
          if (!ack_on)
          begin
            st_nxt.acc = ST_IDLE;
          end
        end
        default:
        begin
          st_nxt.acc = ST_IDLE;
        end
      endcase
      // direction taken at strobe start, held to its end
      case (st_nxt.acc)
        ST_READ:
        begin
          st_nxt.bus.oe = '1;
          st_nxt.bus.dout = reg_pick(st_nxt.regs, idx_s);
        end
        ST_DMA:
        begin
          // dma data ignores the index
          st_nxt.bus.oe = '1;
          st_nxt.bus.dout = dma_out_data;
        end
        default:
        begin
          st_nxt.bus.oe = '0;
          st_nxt.bus.dout = '0;
        end
      endcase
    end
    else
    begin
      // port unselected: pins are plain gpio
      st_nxt.acc = ST_IDLE;
      st_nxt.bus.oe = gpio_ctrl.dir[`HP_GPIO_INDEX_LSB-1:0];
      st_nxt.bus.dout = gpio_ctrl.dout[`HP_GPIO_INDEX_LSB-1:0];
      st_nxt.idx_oe = gpio_ctrl.dir[`HP_GPIO_DIR_BIT-1:`HP_GPIO_INDEX_LSB];
      st_nxt.idx_out = gpio_ctrl.dout[`HP_GPIO_DIR_BIT-1:`HP_GPIO_INDEX_LSB];
      st_nxt.dir_oe = gpio_ctrl.dir[`HP_GPIO_DIR_BIT];
      st_nxt.dir_out = gpio_ctrl.dout[`HP_GPIO_DIR_BIT];
      st_nxt.stb_oe = gpio_ctrl.dir[`HP_GPIO_STROBE_BIT];
      st_nxt.stb_out = gpio_ctrl.dout[`HP_GPIO_STROBE_BIT];
    end
    // output stage of the fifo
    // refills when empty or when taken
    if (drain)
    begin
      st_nxt.rx_valid = fifo_out_valid;
      st_nxt.rx_word = host_word_t'(fifo_out_data);
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.regs <= {`HP_REG_COUNT{`HP_REG_RESET}};
      st_r.gpio_state <= `HP_GPIO_RESET;
      st_r.pin_s1 <= '1;
      st_r.pin_s2 <= '1;
      st_r.ack_s1 <= 1'b1;
      st_r.ack_s2 <= 1'b1;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs, all from flops except the request level, tied low
  // ----------------------------------------
  assign host_data_lines_out = st_r.bus.dout;
  assign host_data_lines_oe = st_r.bus.oe;
  assign host_register_index_out = st_r.idx_out;
  assign host_register_index_oe = st_r.idx_oe;
  assign host_direction_line_out = st_r.dir_out;
  assign host_direction_line_oe = st_r.dir_oe;
  assign host_access_strobe_n_out = st_r.stb_out;
  assign host_access_strobe_n_oe = st_r.stb_oe;
  assign host_service_request_n_out = 1'b0;
  assign host_service_request_n_oe = st_r.req_oe;
  assign gpio_pin_state = st_r.gpio_state;
  assign rx_valid = st_r.rx_valid;
  assign rx_word = st_r.rx_word;

endmodule // host_port_pin_control

// ### host_port_pin_control_tb.sv
module host_port_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import host_port_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  gpio_ctrl_t gctl = '0;
  logic pend = 1'b0;
  logic [2:0] cidx = 3'h0;
  logic [7:0] cdat = 8'h00;
  logic cwe = 1'b0;
  logic [7:0] dmad = 8'h00;
  logic rdy = 1'b0;
  wire logic [7:0] bus, doe, dout;
  wire logic [2:0] idx;
  wire logic rd, stb, ack, rxv;
  wire logic [12:0] pins;
  host_word_t rxw;
  logic [7:0] img [8];
  logic [10:0] expq [$];
  logic [7:0] q;
  int mismatches = 0;
  int checks_done = 0;
  always #12.5 mclk = ~mclk;
  host_port_pin_control DUT (
    .mclk(mclk), .rst(rst), .clk_en(1'b1), .host_port_select(sel), .gpio_ctrl(gctl),
    .gpio_pin_state(pins), .host_data_lines_in(bus), .host_data_lines_out(dout),
    .host_data_lines_oe(doe), .host_register_index_in(idx), .host_register_index_out(),
    .host_register_index_oe(), .host_direction_line_in(rd), .host_direction_line_out(),
    .host_direction_line_oe(), .host_access_strobe_n_in(stb), .host_access_strobe_n_out(),
    .host_access_strobe_n_oe(), .host_dma_acknowledge_n(ack),
    .host_service_request_n_out(), .host_service_request_n_oe(), .core_wr_index(cidx),
    .core_wr_data(cdat), .core_wr_en(cwe), .service_pending(pend), .dma_out_data(dmad),
    .rx_valid(rxv), .rx_ready(rdy), .rx_word(rxw));
  host_bus_model hm (.mclk(mclk), .dev_oe(doe), .dev_out(dout), .bus(bus), .idx(idx),
    .rd(rd), .stb_n(stb), .ack_n(ack));
  // ------
  // checking
  // ------
  function automatic logic [7:0] pin_level(gpio_ctrl_t g, logic [7:0] h);
    return (g.dir[7:0] & g.dout[7:0]) | (~g.dir[7:0] & h);
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t: byte %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic read_all;
    for (int i = 7; i >= 0; i--)
    begin
      hm.access(1'b0, 1'b1, 3'(i), 8'h00, q);
      chk_byte(q, img[i]);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk)
    if (rxv && rdy)
      chk_word(rxw, expq.size() ? expq.pop_front() : 11'hXXX);
  initial
  begin
    repeat (4000) @(posedge mclk);
    mismatches++;
    close_out;
  end
  initial
  begin
    void'($urandom(32'h0E5C048E));
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    chk_byte(doe, 8'h00);
    repeat (4)
    begin
      @(posedge mclk);
      #1;
      gctl = gpio_ctrl_t'(26'($urandom));
      pend = 1'($urandom);
      repeat (5) @(posedge mclk);
      #1;
      chk_byte(pins[7:0], pin_level(gctl, hm.hval));
      chk_byte(8'(pins[12:8]), 8'({stb, rd, idx}));
    end
    gctl = '0;
    pend = 1'b0;
    sel = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      #1;
      cwe = 1'b1;
      cidx = 3'(i);
      cdat = 8'($urandom);
      img[i] = cdat;
    end
    @(posedge mclk);
    #1;
    cwe = 1'b0;
    read_all;
    for (int n = 0; n < 40; n++)
    begin
      logic [10:0] w;
      w = 11'($urandom);
      rdy = (n >= 12) && (n[0] || 1'($urandom));
      expq.push_back(w);
      img[w[2:0]] = w[10:3];
      hm.access(1'b0, 1'b0, w[2:0], w[10:3], q);
    end
    read_all;
    pend = 1'b1;
    dmad = 8'($urandom);
    hm.access(1'b1, 1'b1, 3'h0, 8'h00, q);
    chk_byte(q, dmad);
    pend = 1'b0;
    rdy = 1'b1;
    for (int k = 0; k < 200 && expq.size() != 0; k++)
      @(posedge mclk);
    chk_byte(8'(expq.size()), 8'h00);
    close_out;
  end
endmodule // host_port_pin_control_tb

// ### host_port_pkg.sv
`include "host_port_defines.svh"

package host_port_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b11,
    ST_DMA   = 2'b10
  } access_state_t;

  typedef struct packed {
    logic [`HP_DATA_W-1:0] data;
    logic [`HP_INDEX_W-1:0] index;
  } host_word_t;

  typedef struct packed {
    logic [`HP_GPIO_W-1:0] dout;
    logic [`HP_GPIO_W-1:0] dir;
  } gpio_ctrl_t;

  typedef struct packed {
    logic [`HP_DATA_W-1:0] dout;
    logic [`HP_DATA_W-1:0] oe;
  } bus_drive_t;

endpackage

// ### host_word_fifo.sv
module host_word_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid = (st_r.count != '0);
  assign out_data = mem[st_r.rd_ptr];
  assign push = in_valid && in_ready && clk_en;
  assign pop = out_valid && out_ready && clk_en;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wr_ptr = st_r.wr_ptr + AW'(1);
    end
    if (pop)
    begin
      st_nxt.rd_ptr = st_r.rd_ptr + AW'(1);
    end
    if (push && !pop)
    begin
      st_nxt.count = st_r.count + (AW+1)'(1);
    end
    else if (pop && !push)
    begin
      st_nxt.count = st_r.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[st_r.wr_ptr] <= in_data;
    end
  end

endmodule // host_word_fifo
